// ===== hdl/fsp_flash_ctrl.sv
// flash access, section locks, signature rows and fuses behind apb
// Operation
// - store instruction works only from boot section
// - boot store may target any flash word
// - flash words are sixteen bits wide
// - table region sized as boot, own lock
// - separate locks for application and boot
// - section lock refuses read, write or both
// - software and programmer both reach flash
// - production row readable, never written or erased
// - reset loads the oscillator calibration word automatically
// - production row holds type and serial
// - user row one page, read and written
// - chip erase leaves user row intact
// - only programmer writes fuses, software reads
// - lock bits only tighten, relaxing refused
// - only chip erase or presetn resets the locks
// - locks erased after the flash array
// - unprogrammed reads one, programmed reads zero
//
// Added by the designer: the APB register port and the address map.
module fsp_flash_ctrl
   import fsp_pkg::*;
#(
   parameter logic [15:0] DEV_TYPE = 16'h1234, // arbitrary value
   parameter logic [15:0] SER_LOT = 16'h0001,
   parameter logic [7:0] SER_WAFER = 8'h01,
   parameter logic [7:0] SER_X = 8'h02,
   parameter logic [7:0] SER_Y = 8'h03,
   parameter logic [15:0] CAL_OSC = 16'h0080,
   parameter logic [15:0] CAL_ADC = 16'h0040
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] cpu_pc,
   input wire logic cpu_spm_valid,
   input wire logic [7:0] cpu_spm_addr,
   input wire logic [15:0] cpu_spm_data,
   output logic cpu_spm_ack,
   output logic cpu_spm_err,
   input wire logic dbg_valid,
   input wire logic [3:0] dbg_cmd,
   input wire logic [7:0] dbg_addr,
   input wire logic [15:0] dbg_wdata,
   output logic dbg_ack,
   output logic dbg_err,
   output logic [15:0] dbg_rdata,
   output logic [31:0] fuse_out,
   output logic [15:0] cal_osc
);
   localparam fsp_state_t S_RST = '{st: ST_CAL, lock: `FSP_LOCK_RST,
      fuse: `FSP_FUSE_RST, default: '0};

   fsp_state_t s_q, s_d;
   logic [15:0] flash_q [0:255];
   logic [15:0] us_q [0:15];
   fsp_req_t r_dbg, r_spm, r_apb, g;
   fsp_sect_t g_sect;
   logic ck_rd, ck_wr, pc_boot, acc, setup, unm, bad, rd_hit;
   logic fl_we, us_we, us_er;
   logic [7:0] fl_wa;
   logic [15:0] fl_wd, rd;
   logic [31:0] rdv;

   function automatic logic [15:0] prod_word(input logic [3:0] i);
      case (i)
         4'h0: prod_word = DEV_TYPE;
         4'h1: prod_word = SER_LOT;
         4'h2: prod_word = {SER_WAFER, SER_X};
         4'h3: prod_word = {SER_Y, 8'hFF};
         `FSP_CAL_IDX: prod_word = CAL_OSC;
         4'h5: prod_word = CAL_ADC;
         default: prod_word = `FSP_ERASED;
      endcase
   endfunction

   assign acc = psel && penable && ce;
   assign setup = psel && !penable && ce;
   assign pready = psel && penable && ce;
   assign pslverr = acc && unm;
   assign prdata = s_q.prdata;
   assign cpu_spm_ack = s_q.spm_ack;
   assign cpu_spm_err = s_q.spm_err;
   assign dbg_ack = s_q.dbg_ack;
   assign dbg_err = s_q.dbg_err;
   assign dbg_rdata = s_q.dbg_rdata;
   assign fuse_out = s_q.fuse;
   assign cal_osc = s_q.cal;
   assign pc_boot = fsp_sect_of(cpu_pc) == SECT_BOOT;

   // programmer and store requests are masked while their own ack stands, so a held request runs once
   assign r_dbg = '{valid: dbg_valid && !s_q.dbg_ack, src: SRC_DBG, cmd: dbg_cmd,
      addr: dbg_addr, data: dbg_wdata};
   assign r_spm = '{valid: cpu_spm_valid && !s_q.spm_ack, src: SRC_SPM,
      cmd: `FSP_CMD_WR_FLASH, addr: cpu_spm_addr, data: cpu_spm_data};
   assign r_apb = '{valid: s_q.pend, src: SRC_APB, cmd: s_q.cmd, addr: s_q.addr,
      data: s_q.data};

   fsp_req_arb u_arb (
      .dbg(r_dbg),
      .self_program_store_instr(r_spm),
      .apb(r_apb),
      .hold(s_q.st != ST_IDLE),
      .grant(g)
   );

   // every flash read or write, whichever source, is checked against its target section
   fsp_sect_check u_chk (
      .addr(g.addr),
      .lock(s_q.lock),
      .sect(g_sect),
      .rd_ok(ck_rd),
      .wr_ok(ck_wr)
   );

   always_comb begin
      rdv = 32'h0000_0000;
      unm = 1'b0;
      if (paddr == `FSP_REG_ADDR) begin
         rdv = {24'h00_0000, s_q.addr};
      end else if (paddr == `FSP_REG_DATA) begin
         rdv = {16'h0000, s_q.data};
      end else if (paddr == `FSP_REG_CMD) begin
         rdv = {28'h000_0000, s_q.cmd};
      end else if (paddr == `FSP_REG_CTRL) begin
         rdv = {31'h0000_0000, s_q.pend};
      end else if (paddr == `FSP_REG_STAT) begin
         rdv = {29'h0000_0000, s_q.err, s_q.done, s_q.st != ST_IDLE};
      end else if (paddr == `FSP_REG_LOCK) begin
         rdv = {24'h00_0000, s_q.lock};
      end else if (paddr == `FSP_REG_FUSE) begin
         rdv = s_q.fuse;
      end else if (paddr == `FSP_REG_CAL) begin
         rdv = {16'h0000, s_q.cal};
      end else begin
         unm = 1'b1;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.dbg_ack = 1'b0;
      s_d.dbg_err = 1'b0;
      s_d.spm_ack = 1'b0;
      s_d.spm_err = 1'b0;
      fl_we = 1'b0;
      fl_wa = g.addr;
      fl_wd = g.data;
      us_we = 1'b0;
      us_er = 1'b0;
      rd = 16'h0000;
      rd_hit = 1'b0;
      bad = 1'b0;
      if (setup) begin
         s_d.prdata = rdv;
      end
      if (acc && pwrite) begin
         if (paddr == `FSP_REG_ADDR) begin
            s_d.addr = pwdata[7:0];
         end else if (paddr == `FSP_REG_DATA) begin
            s_d.data = pwdata[15:0];
         end else if (paddr == `FSP_REG_CMD) begin
            s_d.cmd = pwdata[3:0];
         end else if (paddr == `FSP_REG_CTRL && pwdata[`FSP_CTRL_EXEC]) begin
            s_d.pend = 1'b1;
            s_d.done = 1'b0;
            s_d.err = 1'b0;
         end
      end
      case (s_q.st)
         ST_CAL: begin
            // only the oscillator word loads itself, the rest is up to software
            s_d.cal = prod_word(`FSP_CAL_IDX);
            s_d.st = ST_IDLE;
         end
         ST_IDLE: begin
            if (g.valid) begin
               case (g.cmd)
                  `FSP_CMD_RD_FLASH: begin
                     rd_hit = 1'b1;
                     if (ck_rd) begin
                        rd = flash_q[g.addr];
                     end else begin
                        bad = 1'b1;
                     end
                  end
                  `FSP_CMD_WR_FLASH: begin
                     // software writes flash only through the store instruction
                     if (!ck_wr || g.src == SRC_APB) begin
                        bad = 1'b1;
                     end else if (g.src == SRC_SPM && !pc_boot) begin
                        bad = 1'b1;
                     end else begin
                        fl_we = 1'b1;
                     end
                  end
                  `FSP_CMD_RD_PROD: begin
                     rd_hit = 1'b1;
                     rd = prod_word(g.addr[3:0]);
                  end
                  `FSP_CMD_RD_USER: begin
                     rd_hit = 1'b1;
                     rd = us_q[g.addr[3:0]];
                  end
                  `FSP_CMD_WR_USER: us_we = 1'b1;
                  `FSP_CMD_ER_USER: us_er = 1'b1;
                  `FSP_CMD_RD_FUSE: begin
                     rd_hit = 1'b1;
                     rd = {8'h00, s_q.fuse[{g.addr[1:0], 3'b000} +: 8]};
                  end
                  `FSP_CMD_WR_FUSE: begin
                     if (g.src == SRC_DBG) begin
                        s_d.fuse[{g.addr[1:0], 3'b000} +: 8] = g.data[7:0];
                     end else begin
                        bad = 1'b1;
                     end
                  end
                  `FSP_CMD_RD_LOCK: begin
                     rd_hit = 1'b1;
                     rd = {8'h00, s_q.lock};
                  end
                  `FSP_CMD_WR_LOCK: begin
                     // a bit may only go from one to zero, never back
                     if ((g.data[7:0] & ~s_q.lock) != 8'h00) begin
                        bad = 1'b1;
                     end else begin
                        s_d.lock = g.data[7:0];
                     end
                  end
                  `FSP_CMD_CHIP_ER: begin
                     if (g.src == SRC_DBG) begin
                        s_d.st = ST_ER_FLASH;
                        s_d.ecnt = 8'h00;
                     end else begin
                        bad = 1'b1;
                     end
                  end
                  default: bad = 1'b1;
               endcase
               if (g.cmd != `FSP_CMD_CHIP_ER || bad) begin
                  case (g.src)
                     SRC_DBG: begin
                        s_d.dbg_ack = 1'b1;
                        s_d.dbg_err = bad;
                        s_d.dbg_rdata = rd;
                     end
                     SRC_SPM: begin
                        s_d.spm_ack = 1'b1;
                        s_d.spm_err = bad;
                     end
                     default: begin
                        s_d.pend = 1'b0;
                        s_d.done = 1'b1;
                        s_d.err = bad;
                        if (rd_hit && !bad) begin
                           s_d.data = rd;
                        end
                     end
                  endcase
               end
            end
         end
         ST_ER_FLASH: begin
            // locks stay in force while the array is being wiped
            fl_we = 1'b1;
            fl_wa = s_q.ecnt;
            fl_wd = `FSP_ERASED;
            s_d.ecnt = 8'(s_q.ecnt + 8'h01);
            if (s_q.ecnt == `FSP_FL_LAST) begin
               s_d.st = ST_ER_LOCK;
            end
         end
         default: begin
            s_d.lock = `FSP_LOCK_RST;
            s_d.st = ST_IDLE;
            s_d.dbg_ack = 1'b1;
            s_d.dbg_rdata = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= S_RST;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   // arrays are not reset, like the cells they stand for
   always_ff @(posedge pclk) begin
      if (ce) begin
         if (fl_we) begin
            flash_q[fl_wa] <= fl_wd;
         end
         if (us_we) begin
            us_q[g.addr[3:0]] <= g.data;
         end
         if (us_er) begin
            for (int i = 0; i <= 15; i++) begin
               us_q[i] <= `FSP_ERASED;
            end
         end
      end
   end

   logic any_err;
   assign any_err = s_q.dbg_err || s_q.spm_err || (s_q.done && s_q.err);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_spm_app_block: assert property (
      ce && s_q.st == ST_IDLE && g.valid && g.src == SRC_SPM && !pc_boot
      |=> s_q.spm_ack && s_q.spm_err && flash_q[$past(g.addr)] == $past(flash_q[g.addr]))
      else $error("store from application section had effect");
   a_spm_boot_any: assert property (
      ce && s_q.st == ST_IDLE && g.valid && g.src == SRC_SPM && pc_boot && ck_wr
      |=> !s_q.spm_err && flash_q[$past(g.addr)] == $past(g.data))
      else $error("store from boot section not written");
   a_tbl_wlock: assert property (
      ce && s_q.st == ST_IDLE && g.valid && g.cmd == `FSP_CMD_WR_FLASH
      && g_sect == SECT_TBL && !s_q.lock[`FSP_LK_TBL + `FSP_LK_WR] |=> any_err)
      else $error("write into locked table region accepted");
   a_rd_locked: assert property (
      ce && s_q.st == ST_IDLE && g.valid && g.cmd == `FSP_CMD_RD_FLASH && !ck_rd
      |=> any_err)
      else $error("read of read-locked section accepted");
   a_prod_ro: assert property (
      ce && s_q.st == ST_IDLE && g.valid && g.cmd == `FSP_CMD_WR_PROD |=> any_err)
      else $error("production row write not refused");
   a_fuse_sw: assert property (
      ce && s_q.st == ST_IDLE && g.valid && g.cmd == `FSP_CMD_WR_FUSE
      && g.src != SRC_DBG |=> $stable(s_q.fuse) && any_err)
      else $error("fuse changed by software");
   a_lock_tight: assert property (
      (s_q.lock & ~$past(s_q.lock)) != 8'h00 |-> $past(s_q.st) == ST_ER_LOCK)
      else $error("lock relaxed outside chip erase");
   a_erase_order: assert property (
      $rose(s_q.st == ST_ER_LOCK)
      |-> $past(s_q.st) == ST_ER_FLASH && $past(s_q.ecnt) == `FSP_FL_LAST)
      else $error("locks erased before flash was done");
   a_user_keep: assert property (
      s_q.st == ST_ER_FLASH |-> !us_we && !us_er ##1 s_q.st != ST_IDLE)
      else $error("user row touched during chip erase");
   a_cal_load: assert property (
      ce && s_q.st == ST_CAL |=> s_q.cal == CAL_OSC && s_q.st == ST_IDLE)
      else $error("calibration not loaded after reset");

   c_chip_erase: cover property (s_q.st == ST_ER_LOCK ##1 s_q.dbg_ack);
   c_spm_boot: cover property (s_q.spm_ack && !s_q.spm_err);
   c_lock_tight: cover property ($changed(s_q.lock) && s_q.lock != `FSP_LOCK_RST);
endmodule

// ===== hdl/fsp_params.svh
// constants for the flash section protection block
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
`define FSP_TBL_START 8'h80
`define FSP_BOOT_START 8'hC0
`define FSP_FL_LAST 8'hFF
`define FSP_ERASED 16'hFFFF
`define FSP_PAGE_LAST 4'hF
`define FSP_LK_APP 0
`define FSP_LK_TBL 2
`define FSP_LK_BOOT 4
`define FSP_LK_WR 0
`define FSP_LK_RD 1
`define FSP_LOCK_RST 8'hFF
`define FSP_FUSE_RST 32'hFFFF_FFFF
`define FSP_CAL_IDX 4'h4
`define FSP_CMD_RD_FLASH 4'h1
`define FSP_CMD_WR_FLASH 4'h2
`define FSP_CMD_RD_PROD 4'h3
`define FSP_CMD_WR_PROD 4'h4
`define FSP_CMD_RD_USER 4'h5
`define FSP_CMD_WR_USER 4'h6
`define FSP_CMD_ER_USER 4'h7
`define FSP_CMD_RD_FUSE 4'h8
`define FSP_CMD_WR_FUSE 4'h9
`define FSP_CMD_RD_LOCK 4'hA
`define FSP_CMD_WR_LOCK 4'hB
`define FSP_CMD_CHIP_ER 4'hC
`define FSP_REG_ADDR 12'h000
`define FSP_REG_DATA 12'h004
`define FSP_REG_CMD 12'h008
`define FSP_REG_CTRL 12'h00C
`define FSP_REG_STAT 12'h010
`define FSP_REG_LOCK 12'h014
`define FSP_REG_FUSE 12'h018
`define FSP_REG_CAL 12'h01C
`define FSP_CTRL_EXEC 0
`endif

// ===== hdl/fsp_pkg.sv
// types shared by the flash section protection block
`include "fsp_params.svh"
package fsp_pkg;
   typedef enum logic [1:0] {SECT_APP, SECT_TBL, SECT_BOOT} fsp_sect_t;
   typedef enum logic [1:0] {SRC_APB, SRC_SPM, SRC_DBG} fsp_src_t;
   typedef enum logic [1:0] {ST_CAL, ST_IDLE, ST_ER_FLASH, ST_ER_LOCK} fsp_st_t;
   typedef struct packed {
      logic valid;
      fsp_src_t src;
      logic [3:0] cmd;
      logic [7:0] addr;
      logic [15:0] data;
   } fsp_req_t;
   typedef struct packed {
      fsp_st_t st;
      logic [7:0] addr;
      logic [15:0] data;
      logic [3:0] cmd;
      logic pend;
      logic done;
      logic err;
      logic [7:0] lock;
      logic [31:0] fuse;
      logic [15:0] cal;
      logic [7:0] ecnt;
      logic [31:0] prdata;
      logic dbg_ack;
      logic dbg_err;
      logic [15:0] dbg_rdata;
      logic spm_ack;
      logic spm_err;
   } fsp_state_t;

   // table region sits at the top of the application section, boot above it
   function automatic fsp_sect_t fsp_sect_of(input logic [7:0] a);
      if (a >= `FSP_BOOT_START) begin
         return SECT_BOOT;
      end else if (a >= `FSP_TBL_START) begin
         return SECT_TBL;
      end
      return SECT_APP;
   endfunction
endpackage

// ===== hdl/fsp_req_arb.sv
// fixed priority pick among programmer, store instruction and software
module fsp_req_arb
   import fsp_pkg::*;
(
   input wire fsp_req_t dbg,
   input wire fsp_req_t self_program_store_instr,
   input wire fsp_req_t apb,
   input wire logic hold,
   output fsp_req_t grant
);
   always_comb begin
      grant = '0;
      if (!hold) begin
         if (dbg.valid) begin
            grant = dbg;
         end else if (self_program_store_instr.valid) begin
            grant = self_program_store_instr;
         end else if (apb.valid) begin
            grant = apb;
         end
      end
   end
endmodule

// ===== hdl/fsp_sect_check.sv
// section decode and lock permission check for one flash word address
module fsp_sect_check
   import fsp_pkg::*;
(
   input wire logic [7:0] addr,
   input wire logic [7:0] lock,
   output fsp_sect_t sect,
   output logic rd_ok,
   output logic wr_ok
);
   logic [1:0] fld;

   always_comb begin
      sect = fsp_sect_of(addr);
      case (sect)
         SECT_APP: fld = lock[`FSP_LK_APP +: 2];
         SECT_TBL: fld = lock[`FSP_LK_TBL +: 2];
         default: fld = lock[`FSP_LK_BOOT +: 2];
      endcase
      // a programmed (zero) bit blocks the access
      rd_ok = fld[`FSP_LK_RD];
      wr_ok = fld[`FSP_LK_WR];
   end
endmodule

// ===== verif/flash_section_protection_tb_top.sv
// self-checking bench for the flash section protection block
`include "fsp_params.svh"
module flash_section_protection_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] DEV = 16'hA1B2; // arbitrary value
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, fuse_out, rv;
   logic pready, pslverr, lerr, dbg_valid, dbg_ack, dbg_err, cpu_spm_valid, de, to;
   logic cpu_spm_ack, cpu_spm_err;
   logic [3:0] dbg_cmd;
   logic [7:0] dbg_addr, cpu_pc, cpu_spm_addr;
   logic [15:0] dbg_wdata, dbg_rdata, cpu_spm_data, cal_osc, dr;
   int fails = 0;
   int n_compared = 0;
   always #2.5 pclk = ~pclk;
   fsp_flash_ctrl #(.DEV_TYPE(DEV)) fsp_flash_ctrl_inst (.pclk(pclk), .presetn(presetn),
      .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_pc(cpu_pc),
      .cpu_spm_valid(cpu_spm_valid), .cpu_spm_addr(cpu_spm_addr),
      .cpu_spm_data(cpu_spm_data), .cpu_spm_ack(cpu_spm_ack), .cpu_spm_err(cpu_spm_err),
      .dbg_valid(dbg_valid), .dbg_cmd(dbg_cmd), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata),
      .dbg_ack(dbg_ack), .dbg_err(dbg_err), .dbg_rdata(dbg_rdata), .fuse_out(fuse_out),
      .cal_osc(cal_osc));
   fsp_prog_model fsp_prog_model_inst (.pclk(pclk), .dbg_valid(dbg_valid),
      .dbg_cmd(dbg_cmd), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_ack(dbg_ack),
      .dbg_err(dbg_err), .dbg_rdata(dbg_rdata), .cpu_pc(cpu_pc),
      .cpu_spm_valid(cpu_spm_valid), .cpu_spm_addr(cpu_spm_addr),
      .cpu_spm_data(cpu_spm_data), .cpu_spm_ack(cpu_spm_ack), .cpu_spm_err(cpu_spm_err));
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_err(input logic g, input logic e);
      chk_val({31'h0, g}, {31'h0, e});
   endtask
   task automatic hang();
      fails++;
      complete_run();
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) hang();
      r = prdata;
      lerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // software command: load address, data and code, start, poll done
   task automatic sw(input logic [3:0] c, input logic [7:0] a, input logic [15:0] d);
      int n;
      apb(1'b1, `FSP_REG_ADDR, {24'h0, a}, rv);
      apb(1'b1, `FSP_REG_DATA, {16'h0, d}, rv);
      apb(1'b1, `FSP_REG_CMD, {28'h0, c}, rv);
      apb(1'b1, `FSP_REG_CTRL, 32'h1, rv);
      for (n = 0; n < 100; n++) begin
         apb(1'b0, `FSP_REG_STAT, 32'h0, rv);
         if (rv[1] === 1'b1) break;
      end
      if (n == 100) hang();
      de = rv[2];
      apb(1'b0, `FSP_REG_DATA, 32'h0, rv);
      dr = rv[15:0];
   endtask
   task automatic dop(input logic [3:0] c, input logic [7:0] a, input logic [15:0] d);
      fsp_prog_model_inst.dbg_op(c, a, d, dr, de, to);
      if (to) hang();
   endtask
   task automatic self_program_store_instr(input logic [7:0] pc, input logic [7:0] a, input logic [15:0] d);
      fsp_prog_model_inst.spm_op(pc, a, d, de, to);
      if (to) hang();
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `FSP_REG_LOCK, 32'h0, rv);
      chk_val(rv, 32'h0000_00FF);
      apb(1'b0, `FSP_REG_FUSE, 32'h0, rv);
      chk_val(rv, 32'hFFFF_FFFF);
      apb(1'b0, `FSP_REG_CAL, 32'h0, rv);
      chk_val(rv, 32'h0000_0080);
      chk_val({16'h0, cal_osc}, 32'h0000_0080);
      apb(1'b0, 12'h020, 32'h0, rv);
      chk_err(lerr, 1'b1);
      dop(`FSP_CMD_RD_PROD, 8'h00, 16'h0000);
      chk_val({16'h0, dr}, {16'h0, DEV});
      dop(`FSP_CMD_RD_PROD, 8'h02, 16'h0000);
      chk_val({16'h0, dr}, 32'h0000_0102);
      dop(`FSP_CMD_WR_PROD, 8'h04, 16'h0000);
      chk_err(de, 1'b1);
      sw(`FSP_CMD_RD_PROD, 8'h04, 16'h0000);
      chk_val({16'h0, dr}, 32'h0000_0080);
      dop(`FSP_CMD_WR_FLASH, 8'h20, 16'hA55A);
      chk_err(de, 1'b0);
      self_program_store_instr(8'h10, 8'h20, 16'h0000);
      chk_err(de, 1'b1);
      dop(`FSP_CMD_RD_FLASH, 8'h20, 16'h0000);
      chk_val({16'h0, dr}, 32'h0000_A55A);
      self_program_store_instr(8'hC0, 8'hC8, 16'h2222);
      chk_err(de, 1'b0);
      sw(`FSP_CMD_RD_FLASH, 8'hC8, 16'h0000);
      chk_val({15'h0, de, dr}, 32'h0000_2222);
      dop(`FSP_CMD_WR_LOCK, 8'h00, 16'h00FE);
      chk_err(de, 1'b0);
      dop(`FSP_CMD_WR_LOCK, 8'h00, 16'h00FF);
      chk_err(de, 1'b1);
      self_program_store_instr(8'hFF, 8'h7F, 16'h0000);
      chk_err(de, 1'b1);
      self_program_store_instr(8'hFF, 8'h80, 16'h3333);
      chk_err(de, 1'b0);
      dop(`FSP_CMD_WR_LOCK, 8'h00, 16'h00F2);
      apb(1'b0, `FSP_REG_LOCK, 32'h0, rv);
      chk_val(rv, 32'h0000_00F2);
      sw(`FSP_CMD_WR_LOCK, 8'h00, 16'h00FE);
      chk_err(de, 1'b1);
      dop(`FSP_CMD_RD_FLASH, 8'hBF, 16'h0000);
      chk_err(de, 1'b1);
      sw(`FSP_CMD_RD_FLASH, 8'h90, 16'h0000);
      chk_err(de, 1'b1);
      dop(`FSP_CMD_RD_FLASH, 8'h20, 16'h0000);
      chk_val({15'h0, de, dr}, 32'h0000_A55A);
      dop(`FSP_CMD_RD_FLASH, 8'hC0, 16'h0000);
      chk_err(de, 1'b0);
      dop(`FSP_CMD_WR_USER, 8'h03, 16'hABCD);
      sw(`FSP_CMD_WR_USER, 8'h04, 16'h5678);
      chk_err(de, 1'b0);
      dop(`FSP_CMD_RD_USER, 8'h04, 16'h0000);
      chk_val({16'h0, dr}, 32'h0000_5678);
      sw(`FSP_CMD_WR_FUSE, 8'h00, 16'h00A5);
      chk_err(de, 1'b1);
      // programmer writes a fuse value other than the erased pattern
      dop(`FSP_CMD_WR_FUSE, 8'h00, 16'h00A5);
      chk_val(fuse_out, 32'hFFFF_FFA5);
      sw(`FSP_CMD_RD_FUSE, 8'h00, 16'h0000);
      chk_val({16'h0, dr}, 32'h0000_00A5);
      fork
         dop(`FSP_CMD_CHIP_ER, 8'h00, 16'h0000);
         begin
            repeat (100) @(posedge pclk);
            apb(1'b0, `FSP_REG_LOCK, 32'h0, rv);
            chk_val(rv, 32'h0000_00F2);
         end
      join
      chk_err(de, 1'b0);
      apb(1'b0, `FSP_REG_LOCK, 32'h0, rv);
      chk_val(rv, 32'h0000_00FF);
      dop(`FSP_CMD_RD_FLASH, 8'h80, 16'h0000);
      chk_val({15'h0, de, dr}, 32'h0000_FFFF);
      dop(`FSP_CMD_RD_USER, 8'h03, 16'h0000);
      chk_val({16'h0, dr}, 32'h0000_ABCD);
      chk_val(fuse_out, 32'hFFFF_FFA5);
      dop(`FSP_CMD_ER_USER, 8'h00, 16'h0000);
      dop(`FSP_CMD_RD_USER, 8'h03, 16'h0000);
      chk_val({16'h0, dr}, 32'h0000_FFFF);
      complete_run();
   end
endmodule

// ===== verif/fsp_prog_model.sv
// programmer and store instruction requester facing the flash block
module fsp_prog_model (
   input wire logic pclk,
   output logic dbg_valid,
   output logic [3:0] dbg_cmd,
   output logic [7:0] dbg_addr,
   output logic [15:0] dbg_wdata,
   input wire logic dbg_ack,
   input wire logic dbg_err,
   input wire logic [15:0] dbg_rdata,
   output logic [7:0] cpu_pc,
   output logic cpu_spm_valid,
   output logic [7:0] cpu_spm_addr,
   output logic [15:0] cpu_spm_data,
   input wire logic cpu_spm_ack,
   input wire logic cpu_spm_err
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      dbg_valid = 1'b0;
      dbg_cmd = 4'h0;
      dbg_addr = 8'h00;
      dbg_wdata = 16'h0000;
      cpu_pc = 8'h00;
      cpu_spm_valid = 1'b0;
      cpu_spm_addr = 8'h00;
      cpu_spm_data = 16'h0000;
   end
   // request held until the edge that samples ack; released address and data lines show the inverse
   task automatic dbg_op(input logic [3:0] c, input logic [7:0] a, input logic [15:0] d,
                         output logic [15:0] r, output logic e, output logic to);
      int n;
      @(posedge pclk);
      dbg_valid <= 1'b1;
      dbg_cmd <= c;
      dbg_addr <= a;
      dbg_wdata <= d;
      to = 1'b1;
      for (n = 0; n < 400; n++) begin
         @(posedge pclk);
         if (dbg_ack === 1'b1) begin
            to = 1'b0;
            break;
         end
      end
      r = dbg_rdata;
      e = dbg_err;
      dbg_valid <= 1'b0;
      dbg_addr <= ~a;
      dbg_wdata <= ~d;
   endtask
   task automatic spm_op(input logic [7:0] pc, input logic [7:0] a, input logic [15:0] d,
                         output logic e, output logic to);
      int n;
      @(posedge pclk);
      cpu_pc <= pc;
      cpu_spm_valid <= 1'b1;
      cpu_spm_addr <= a;
      cpu_spm_data <= d;
      to = 1'b1;
      for (n = 0; n < 400; n++) begin
         @(posedge pclk);
         if (cpu_spm_ack === 1'b1) begin
            to = 1'b0;
            break;
         end
      end
      e = cpu_spm_err;
      cpu_spm_valid <= 1'b0;
      cpu_spm_addr <= ~a;
      cpu_spm_data <= ~d;
   endtask
endmodule
